// ### pkg/scan_if_pkg.sv
package scan_if_pkg;

	// ****************************************************************
	// Register map (word index on the plain register port)
	// ****************************************************************
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] CTL3_IDX = 3'h0;
	localparam logic [ADDR_W-1:0] CTL4_IDX = 3'h1;
	localparam logic [ADDR_W-1:0] COUNT_IDX = 3'h2;
	localparam logic [ADDR_W-1:0] STATUS_IDX = 3'h3;
	localparam logic [ADDR_W-1:0] MASK_IDX = 3'h4;

	localparam logic [DATA_W-1:0] CTL3_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] CTL4_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;

	// ****************************************************************
	// Status and mask bit positions
	// ****************************************************************
	localparam int ZERO_FLAG_BIT = 0;
	localparam int THIRD_FLAG_BIT = 3;

	// ****************************************************************
	// Third flag source codes and modulo masks
	// ****************************************************************
	localparam logic [1:0] THIRD_EVERY = 2'h0;
	localparam logic [1:0] THIRD_MOD4 = 2'h1;
	localparam logic [1:0] THIRD_MOD64 = 2'h2;
	localparam logic [7:0] MOD4_MASK = 8'h03;
	localparam logic [7:0] MOD64_MASK = 8'h3F;

	localparam int PRE_W = 3;
	localparam int TRIG_W = 9;
	localparam logic [PRE_W-1:0] PRE_ZERO = 3'h0;
	localparam logic [TRIG_W-1:0] TRIG_ZERO = 9'h000;
	localparam logic [7:0] CNT_ZERO = 8'h00;

	// ****************************************************************
	// Register layouts
	// ****************************************************************
	typedef struct packed {
		logic [1:0] second_source_select;
		logic [1:0] first_source_select;
		logic [1:0] fourth_flag_source;
		logic [1:0] third_flag_source;
		logic capture_route_select;
		logic [2:0] zero_flag_source;
		logic [3:0] frontend_out;
	} ctl3_type;

	typedef struct packed {
		logic clear_on_read;
		logic counter_two_enable;
		logic counter_one_decrement_enable;
		logic counter_one_increment_enable;
		logic state_bit_seven_enable;
		logic state_bit_six_enable;
		logic [2:0] trigger_divider_b;
		logic [2:0] trigger_divider_a;
		logic [1:0] aux_clock_divider;
		logic [1:0] sequencer_clock_divider;
	} ctl4_type;

	// Inputs handed to the processing state machine
	typedef struct packed {
		logic first_source;
		logic second_source;
		logic state_bit_six;
		logic state_bit_seven;
	} psm_inputs_type;

	// Counting requests from the processing state machine
	typedef struct packed {
		logic counter_one_up;
		logic counter_one_down;
		logic counter_two_step;
	} count_events_type;

endpackage

// ### hw/scan_if_control.sv
// Chosen here: strobed register access and the register offsets.
module scan_if_control (
	input wire logic MCLK_I,
	input wire logic RESET_I,
	input wire logic [scan_if_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [scan_if_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [scan_if_pkg::DATA_W-1:0] RDATA_O,
	input wire logic [3:0] FRONTEND_OUT_I,
	input wire logic SCAN_SELECT_I,
	input wire logic STATE_BIT_SIX_I,
	input wire logic STATE_BIT_SEVEN_I,
	input wire scan_if_pkg::count_events_type COUNT_EVENTS_I,
	output scan_if_pkg::psm_inputs_type PSM_INPUTS_O,
	output logic AUX_TICK_O,
	output logic TRIGGER_O,
	output logic SEQ_TICK_O,
	output logic IRQ_O
);
	import scan_if_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Last prescaler count for a /1, /2, /4, /8 code
	function automatic logic [PRE_W-1:0] pow2_limit(input logic [1:0] code);
		logic [PRE_W-1:0] lim;
		lim = PRE_ZERO;
		case (code)
			2'h0: lim = 3'h0;
			2'h1: lim = 3'h1;
			2'h2: lim = 3'h3;
			2'h3: lim = 3'h7;
			default: lim = PRE_ZERO;
		endcase
		return lim;
	endfunction

	// Rate is 2*(2A+1)*(2B+1); returns rate minus one
	function automatic logic [TRIG_W-1:0] trig_limit(input logic [2:0] a,
		input logic [2:0] b);
		logic [TRIG_W-1:0] fa;
		logic [TRIG_W-1:0] fb;
		logic [TRIG_W-1:0] rate;
		fa = {5'h00, a, 1'b1};
		fb = {5'h00, b, 1'b1};
		rate = TRIG_W'((fa * fb) << 1);
		return TRIG_W'(rate - 9'h001);
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		ctl3_type ctl3;
		ctl4_type ctl4;
		logic [7:0] counter_one;
		logic [7:0] counter_two;
		logic [DATA_W-1:0] status;
		logic [DATA_W-1:0] mask;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] frontend;
		logic [PRE_W-1:0] aux_cnt;
		logic [PRE_W-1:0] seq_cnt;
		logic [TRIG_W-1:0] trig_cnt;
		logic aux_tick;
		logic seq_tick;
		logic trigger;
		psm_inputs_type processing_state_machine;
		logic irq;
		logic [DATA_W-1:0] rdata;
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic wr_ctl3;
	logic wr_ctl4;
	logic wr_mask;
	logic rd_count;
	logic rd_status;
	logic c1_up;
	logic c1_down;
	logic c1_step;
	logic c2_step;
	logic [3:0] fe_filtered;
	logic zero_event;
	logic third_event;
	logic [7:0] c1_after;
	logic s2_pick;
	logic aux_wrap;
	logic seq_wrap;
	logic trig_wrap;

	assign wr_ctl3 = WR_I && (ADDR_I == CTL3_IDX);
	assign wr_ctl4 = WR_I && (ADDR_I == CTL4_IDX);
	assign wr_mask = WR_I && (ADDR_I == MASK_IDX);
	assign rd_count = RD_I && (ADDR_I == COUNT_IDX);
	assign rd_status = RD_I && (ADDR_I == STATUS_IDX);

	// Counter one gating; simultaneous up and down cancel
	assign c1_up = COUNT_EVENTS_I.counter_one_up &&
		state_reg.ctl4.counter_one_increment_enable;
	assign c1_down = COUNT_EVENTS_I.counter_one_down &&
		state_reg.ctl4.counter_one_decrement_enable;
	assign c1_step = c1_up ^ c1_down;
	assign c2_step = COUNT_EVENTS_I.counter_two_step &&
		state_reg.ctl4.counter_two_enable;
	assign c1_after = c1_up ? 8'(state_reg.counter_one + 8'h01) :
		8'(state_reg.counter_one - 8'h01);

	// Front-end bits accepted once all four agree between second and third stages
	assign fe_filtered = (state_reg.sync2 == state_reg.sync3) ?
		state_reg.sync3 : state_reg.frontend;

	always_comb begin
		logic [1:0] zsel;
		logic zpol;
		zsel = state_reg.ctl3.zero_flag_source[2:1];
		zpol = state_reg.ctl3.zero_flag_source[0];
		zero_event = (fe_filtered[zsel] != state_reg.frontend[zsel]) &&
			(fe_filtered[zsel] == !zpol);
	end

	always_comb begin
		third_event = 1'b0;
		if (c1_step) begin
			case (state_reg.ctl3.third_flag_source)
				THIRD_EVERY: third_event = 1'b1;
				THIRD_MOD4: third_event = (c1_after & MOD4_MASK) == CNT_ZERO;
				THIRD_MOD64: third_event = (c1_after & MOD64_MASK) == CNT_ZERO;
				default: third_event = 1'b0;
			endcase
		end
	end

	assign s2_pick = SCAN_SELECT_I &&
		state_reg.frontend[state_reg.ctl3.second_source_select];
	assign aux_wrap = state_reg.aux_cnt >=
		pow2_limit(state_reg.ctl4.aux_clock_divider);
	assign seq_wrap = state_reg.seq_cnt >=
		pow2_limit(state_reg.ctl4.sequencer_clock_divider);
	assign trig_wrap = state_reg.trig_cnt >=
		trig_limit(state_reg.ctl4.trigger_divider_a,
		state_reg.ctl4.trigger_divider_b);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [DATA_W-1:0] flags;
		flags = WORD_ZERO;
		state_next = state_reg;

		state_next.sync1 = FRONTEND_OUT_I;
		state_next.sync2 = state_reg.sync1;
		state_next.sync3 = state_reg.sync2;
		state_next.frontend = fe_filtered;

		// Register writes; front-end bits of control three are read-only
		if (wr_ctl3) begin
			state_next.ctl3 = ctl3_type'(WDATA_I);
		end
		state_next.ctl3.frontend_out = fe_filtered;
		if (wr_ctl4) begin
			state_next.ctl4 = ctl4_type'(WDATA_I);
		end
		if (wr_mask) begin
			state_next.mask = WDATA_I;
		end

		// Count register: clear on read first, a count in the same cycle wins
		if (rd_count && state_reg.ctl4.clear_on_read) begin
			state_next.counter_one = CNT_ZERO;
			state_next.counter_two = CNT_ZERO;
		end
		if (c1_step) begin
			state_next.counter_one = rd_count && state_reg.ctl4.clear_on_read ?
				(c1_up ? 8'h01 : 8'hFF) : c1_after;
		end
		if (c2_step) begin
			state_next.counter_two = rd_count && state_reg.ctl4.clear_on_read ?
				8'h01 : 8'(state_reg.counter_two + 8'h01);
		end

		// Sticky flags, cleared by a read, a new event wins over the clear
		flags[ZERO_FLAG_BIT] = zero_event;
		flags[THIRD_FLAG_BIT] = third_event;
		state_next.status = (rd_status ? WORD_ZERO : state_reg.status) | flags;
		state_next.irq = |(state_next.status & state_next.mask);

		// Read data stands for one cycle only
		state_next.rdata = WORD_ZERO;
		if (RD_I) begin
			case (ADDR_I)
				CTL3_IDX: state_next.rdata = state_reg.ctl3;
				CTL4_IDX: state_next.rdata = state_reg.ctl4;
				COUNT_IDX: state_next.rdata = {state_reg.counter_two,
					state_reg.counter_one};
				STATUS_IDX: state_next.rdata = state_reg.status;
				MASK_IDX: state_next.rdata = state_reg.mask;
				default: state_next.rdata = WORD_ZERO;
			endcase
		end

		// Inputs of the processing state machine
		state_next.processing_state_machine.second_source = s2_pick;
		state_next.processing_state_machine.first_source = SCAN_SELECT_I &&
			state_reg.frontend[state_reg.ctl3.first_source_select];
		state_next.processing_state_machine.state_bit_six = STATE_BIT_SIX_I &&
			state_reg.ctl4.state_bit_six_enable;
		state_next.processing_state_machine.state_bit_seven = STATE_BIT_SEVEN_I &&
			state_reg.ctl4.state_bit_seven_enable;

		// Aux prescaler and start trigger divider
		state_next.aux_tick = aux_wrap;
		state_next.aux_cnt = aux_wrap ? PRE_ZERO :
			PRE_W'(state_reg.aux_cnt + 3'h1);
		state_next.trigger = 1'b0;
		if (state_reg.aux_tick) begin
			state_next.trigger = trig_wrap;
			state_next.trig_cnt = trig_wrap ? TRIG_ZERO :
				TRIG_W'(state_reg.trig_cnt + 9'h001);
		end

		// Sequencer clock prescaler
		state_next.seq_tick = seq_wrap;
		state_next.seq_cnt = seq_wrap ? PRE_ZERO :
			PRE_W'(state_reg.seq_cnt + 3'h1);
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			state_reg <= '0;
			state_reg.ctl3 <= ctl3_type'(CTL3_RESET);
			state_reg.ctl4 <= ctl4_type'(CTL4_RESET);
		end else begin
			state_reg <= state_next;
		end
	end

	assign RDATA_O = state_reg.rdata;
	assign PSM_INPUTS_O = state_reg.processing_state_machine;
	assign AUX_TICK_O = state_reg.aux_tick;
	assign TRIGGER_O = state_reg.trigger;
	assign SEQ_TICK_O = state_reg.seq_tick;
	assign IRQ_O = state_reg.irq;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (RESET_I);

	sequence read_with_clear;
		rd_count && state_reg.ctl4.clear_on_read && !c1_step && !c2_step;
	endsequence

	sequence counts_cleared;
		state_reg.counter_one == CNT_ZERO && state_reg.counter_two == CNT_ZERO;
	endsequence

	a_s2_select: assert property (##1 PSM_INPUTS_O.second_source ==
		$past(s2_pick))
		else $error("second source differs from selected front-end bit");

	a_third_every: assert property (c1_step &&
		state_reg.ctl3.third_flag_source == THIRD_EVERY |=>
		state_reg.status[THIRD_FLAG_BIT])
		else $error("third flag missed a counter one count");

	a_zero_flag: assert property (zero_event |=>
		state_reg.status[ZERO_FLAG_BIT] &&
		(IRQ_O || !state_reg.mask[ZERO_FLAG_BIT]))
		else $error("zero flag or interrupt not raised");

	a_clear_read: assert property (read_with_clear |=>
		counts_cleared ##0 RDATA_O != WORD_ZERO || $past(rd_count) &&
		$past(state_reg.counter_one) == CNT_ZERO &&
		$past(state_reg.counter_two) == CNT_ZERO)
		else $error("count register not cleared after read");

	a_keep_read: assert property (rd_count &&
		!state_reg.ctl4.clear_on_read && !c1_step && !c2_step |=>
		$stable(state_reg.counter_one) && $stable(state_reg.counter_two))
		else $error("count changed by a plain read");

	a_inc_gate: assert property (
		!state_reg.ctl4.counter_one_increment_enable && !c1_down &&
		!(rd_count && state_reg.ctl4.clear_on_read) |=>
		$stable(state_reg.counter_one))
		else $error("counter one moved with increment disabled");

	a_q6_gate: assert property (
		!state_reg.ctl4.state_bit_six_enable |=>
		!PSM_INPUTS_O.state_bit_six)
		else $error("state bit six passed while disabled");

	a_cnt2_gate: assert property (
		!state_reg.ctl4.counter_two_enable && !rd_count |=>
		$stable(state_reg.counter_two))
		else $error("counter two moved while disabled");

	a_trig_rate: assert property (TRIGGER_O |-> $past(trig_wrap) &&
		$past(state_reg.aux_tick))
		else $error("trigger without divider wrap");

	a_aux_rate: assert property (AUX_TICK_O |-> $past(aux_wrap) &&
		$past(state_reg.aux_cnt) >=
		$past(pow2_limit(state_reg.ctl4.aux_clock_divider)))
		else $error("aux tick before prescaler end");

	a_seq_rate: assert property (SEQ_TICK_O |-> $past(seq_wrap) ##1
		(!SEQ_TICK_O || state_reg.ctl4.sequencer_clock_divider == 2'h0 ||
		$past(wr_ctl4)))
		else $error("sequencer tick spacing wrong");

endmodule

// ### bench/frontend_model.sv
module frontend_model (
	input wire logic clk_i,
	input wire logic [3:0] level_i,
	output logic [3:0] bits_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Analogue outputs settle a few ns after the comparator decides
	// ********
	initial begin
		bits_o = 4'h0;
	end
	always @(posedge clk_i) begin
		bits_o <= #7 level_i;
	end
endmodule

// ### bench/test_scan_if_control.sv
module test_scan_if_control;
	timeunit 1ns;
	timeprecision 1ps;
	import scan_if_pkg::*;
	localparam logic [15:0] CFGS [4] = '{16'h7000, 16'h3000, 16'hD000,
		16'h6000};
	logic clk, rst, wr, rd, ssel, b6, b7, irq;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wd, rdata, cfg;
	logic [3:0] fe_lvl, fe;
	logic [2:0] tk, e;
	count_events_type ev;
	psm_inputs_type processing_state_machine;
	int n_fail, total_checks, m1, m2, st3, i, p, k, c;
	int unsigned seed;
	logic up, dn;

	frontend_model fem_u (.clk_i(clk), .level_i(fe_lvl), .bits_o(fe));
	scan_if_control dut_u (.MCLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
		.WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.FRONTEND_OUT_I(fe), .SCAN_SELECT_I(ssel),
		.STATE_BIT_SIX_I(b6), .STATE_BIT_SEVEN_I(b7),
		.COUNT_EVENTS_I(ev), .PSM_INPUTS_O(processing_state_machine), .AUX_TICK_O(tk[0]),
		.TRIGGER_O(tk[2]), .SEQ_TICK_O(tk[1]), .IRQ_O(irq));

	// ********
	// Helpers
	// ********
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		total_checks++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wrt(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [15:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, x);
	endtask
	// Spacing in cycles between two pulses of one tick output
	task automatic gap(input int w, input int x);
		int j;
		int n;
		cyc(1);
		j = 0;
		while (tk[w] !== 1'b1 && j < 999) begin
			cyc(1);
			j++;
		end
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (tk[w] !== 1'b1 && n < 999);
		if (j >= 999 || n >= 999) begin
			n_fail++;
			conclude();
		end
		chk(n, x);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ********
	// Main sequence
	// ********
	initial begin
		rst = 1'b1;
		{wr, rd, ssel, b6, b7} = '0;
		addr = '0;
		wd = '0;
		fe_lvl = '0;
		ev = '0;
		seed = 30461;
		n_fail = 0;
		total_checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdc(CTL3_IDX, CTL3_RESET);
		rdc(CTL4_IDX, CTL4_RESET);
		rdc(3'h5, WORD_ZERO);
		rdc(COUNT_IDX, WORD_ZERO);
		cfg = xs();
		wrt(CTL4_IDX, cfg);
		rdc(CTL4_IDX, cfg);
		wrt(3'h7, 16'hFFFF);
		rdc(3'h7, WORD_ZERO);
		wrt(MASK_IDX, 16'h0009);
		{m1, m2, st3} = '0;
		for (p = 0; p < 4; p++) begin
			cfg = CFGS[p];
			wrt(CTL4_IDX, cfg);
			wrt(CTL3_IDX, p << 8);
			rdc(STATUS_IDX, WORD_ZERO);
			for (i = 0; i < 24; i++) begin
				e = xs();
				up = e[2] & cfg[12];
				dn = e[1] & cfg[13];
				if (up != dn) begin
					m1 = (m1 + (up ? 1 : -1)) & 255;
					if (p == 0 || (p == 1 && m1 % 4 == 0) ||
						(p == 2 && m1 % 64 == 0)) begin
						st3 = 1;
					end
				end
				if (e[0] & cfg[14]) begin
					m2 = (m2 + 1) & 255;
				end
				@(posedge clk);
				ev <= e;
				@(posedge clk);
				ev <= '0;
				cyc(2);
				chk(irq, st3);
				rdc(STATUS_IDX, st3 << 3);
				st3 = 0;
			end
			rdc(COUNT_IDX, (m2 << 8) | m1);
			if (cfg[15]) begin
				{m1, m2} = '0;
			end
			rdc(COUNT_IDX, (m2 << 8) | m1);
		end
		for (c = 0; c < 8; c++) begin
			k = c >> 1;
			wrt(CTL3_IDX, c << 4);
			wrt(MASK_IDX, c % 2);
			@(posedge clk);
			fe_lvl[k] <= 1'b1;
			cyc(8);
			rdc(CTL3_IDX, (c << 4) | (1 << k));
			chk(irq, 1'b0);
			rdc(STATUS_IDX, c % 2 == 0);
			@(posedge clk);
			fe_lvl[k] <= 1'b0;
			cyc(8);
			chk(irq, c % 2);
			rdc(STATUS_IDX, c % 2);
		end
		for (k = 0; k < 4; k++) begin
			wrt(CTL4_IDX, (k << 2) | k);
			gap(0, 1 << k);
			gap(1, 1 << k);
			gap(2, 2 << k);
		end
		wrt(CTL4_IDX, 16'h0110);
		gap(2, 30);
		wrt(CTL4_IDX, 16'h0390);
		gap(2, 90);
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			ssel <= 1'b1;
			b6 <= 1'b1;
			b7 <= 1'b1;
			fe_lvl <= xs();
			wrt(CTL4_IDX, i << 10);
			wrt(CTL3_IDX, (i << 14) | ((3 - i) << 12));
			cyc(8);
			chk(processing_state_machine, {fe_lvl[3 - i], fe_lvl[i], i[0], i[1]});
		end
		@(posedge clk);
		ssel <= 1'b0;
		cyc(3);
		chk(processing_state_machine[3:2], 2'b00);
		conclude();
	end
endmodule
